// ===== hw/uart_multidrop.sv
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module uart_multidrop #(
	parameter int OVS = 16
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	// Register bus
	input  wire uart_pkg::axil_req_type bus_req,
	output var  uart_pkg::axil_rsp_type bus_rsp,
	// Port pin configuration
	input  wire logic                  pin_alt_en,
	// Serial line
	input  wire logic                  rxd,
	input  wire logic                  cts_n,
	output logic                       txd,
	// Interrupt requests
	output logic                       tx_irq,
	output logic                       rx_irq
);
	localparam int PW = $clog2(OVS);
	localparam logic [PW-1:0] PH_LAST = PW'(OVS - 1);
	localparam logic [PW-1:0] PH_MID  = PW'(OVS / 2 - 1);

	if (OVS < 4 || (OVS & (OVS - 1)) != 0) begin : g_bad_ovs
		$error("OVS must be a power of two, at least 4");
	end

	uart_pkg::axil_rsp_type rsp_q;
	logic        aw_held_q, w_held_q;
	logic [31:0] waddr_q, wdata_q;
	logic [3:0]  wstrb_q;
	logic [7:0]  ctrl0_q, ctrl1_q, addr_q, tx_hold_q, rx_data_q;
	logic [15:0] baud_q, baud_cnt_q;
	logic        hold_full_q, tx_irq_q, rx_irq_q, txd_q;
	logic        rxd_s1, rxd_s2, cts_s1, cts_s2;
	uart_pkg::ser_state_type tx_st_q;
	logic        avail_q, perr_q, ferr_q, ovr_q, brk_q, marker_q, newfrm_q, irq_ok_q;
	logic        matched_q, first_q;

	assign bus_rsp = rsp_q;
	assign txd     = txd_q;
	assign tx_irq  = tx_irq_q;
	assign rx_irq  = rx_irq_q;

	// Control fields
	logic tx_en, rx_en, flow_en, par_en, par_odd, stop2, mp_en, marker, data_irq;
	logic [1:0] scheme;
	assign tx_en    = ctrl0_q[uart_pkg::C0_TX_EN];
	assign rx_en    = ctrl0_q[uart_pkg::C0_RX_EN];
	assign flow_en  = ctrl0_q[uart_pkg::C0_FLOW];
	assign par_en   = ctrl0_q[uart_pkg::C0_PAR_EN];
	assign par_odd  = ctrl0_q[uart_pkg::C0_PAR_ODD];
	assign stop2    = ctrl0_q[uart_pkg::C0_STOP2];
	assign mp_en    = ctrl1_q[uart_pkg::C1_MP_EN];
	assign marker   = ctrl1_q[uart_pkg::C1_MARKER];
	assign data_irq = ctrl1_q[uart_pkg::C1_DATA_IRQ];
	assign scheme   = ctrl1_q[uart_pkg::C1_SCH_HI:uart_pkg::C1_SCH_LO];

	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxd_s1 <= 1'b1;
			rxd_s2 <= 1'b1;
			cts_s1 <= 1'b1;
			cts_s2 <= 1'b1;
		end else begin
			rxd_s1 <= rxd;
			rxd_s2 <= rxd_s1;
			cts_s1 <= cts_n;
			cts_s2 <= cts_s1;
		end
	end

	logic line;
	assign line = pin_alt_en ? rxd_s2 : 1'b1;

	// Bus decode
	logic wr_go, wr_ok, rd_go, rd_ok, rd_pop;
	logic [4:0] wofs, rofs;
	logic [31:0] rd_val;
	assign wofs   = waddr_q[4:0];
	assign rofs   = bus_req.araddr[4:0];
	assign wr_go  = aw_held_q & w_held_q & ~rsp_q.bvalid;
	assign wr_ok  = waddr_q[31:5] == 27'h0000000 && waddr_q[1:0] == 2'h0;
	assign rd_go  = bus_req.arvalid & rsp_q.arready;
	assign rd_ok  = bus_req.araddr[31:5] == 27'h0000000 && bus_req.araddr[1:0] == 2'h0;
	assign rd_pop = rd_go & rd_ok & rofs == uart_pkg::OFS_DATA;

	function automatic logic wsel(input logic [4:0] ofs);
		return wr_go & wr_ok & wstrb_q[0] & wofs == ofs;
	endfunction

	always_comb begin
		rd_val = 32'h00000000;
		case (rofs)
			uart_pkg::OFS_DATA:  rd_val[7:0] = rx_data_q;
			uart_pkg::OFS_STAT0: rd_val[7:0] = {avail_q, perr_q, ovr_q, ferr_q, brk_q,
				~hold_full_q, tx_st_q == uart_pkg::ST_IDLE, ~cts_s2};
			uart_pkg::OFS_CTRL0: rd_val[7:0] = ctrl0_q;
			uart_pkg::OFS_CTRL1: rd_val[7:0] = ctrl1_q;
			uart_pkg::OFS_STAT1: rd_val[7:0] = {6'h00, newfrm_q, marker_q};
			uart_pkg::OFS_ADDR:  rd_val[7:0] = addr_q;
			uart_pkg::OFS_BAUDH: rd_val[7:0] = baud_q[15:8];
			uart_pkg::OFS_BAUDL: rd_val[7:0] = baud_q[7:0];
			default:             rd_val = 32'h00000000;
		endcase
	end

	// Bus slave handshakes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rsp_q         <= '0;
			rsp_q.awready <= 1'b1;
			rsp_q.wready  <= 1'b1;
			rsp_q.arready <= 1'b1;
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			waddr_q       <= 32'h00000000;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
		end else begin
			if (bus_req.awvalid && rsp_q.awready) begin
				waddr_q       <= bus_req.awaddr;
				aw_held_q     <= 1'b1;
				rsp_q.awready <= 1'b0;
			end
			if (bus_req.wvalid && rsp_q.wready) begin
				wdata_q      <= bus_req.wdata;
				wstrb_q      <= bus_req.wstrb;
				w_held_q     <= 1'b1;
				rsp_q.wready <= 1'b0;
			end
			if (wr_go) begin
				rsp_q.bvalid <= 1'b1;
				rsp_q.bresp  <= wr_ok ? uart_pkg::RESP_OKAY : uart_pkg::RESP_DECERR;
				aw_held_q    <= 1'b0;
				w_held_q     <= 1'b0;
			end
			if (rsp_q.bvalid && bus_req.bready) begin
				rsp_q.bvalid  <= 1'b0;
				rsp_q.awready <= 1'b1;
				rsp_q.wready  <= 1'b1;
			end
			if (rd_go) begin
				rsp_q.arready <= 1'b0;
				rsp_q.rvalid  <= 1'b1;
				rsp_q.rdata   <= rd_ok ? rd_val : 32'h00000000;
				rsp_q.rresp   <= rd_ok ? uart_pkg::RESP_OKAY : uart_pkg::RESP_DECERR;
			end
			if (rsp_q.rvalid && bus_req.rready) begin
				rsp_q.rvalid  <= 1'b0;
				rsp_q.arready <= 1'b1;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl0_q <= uart_pkg::RST_CTRL;
			ctrl1_q <= uart_pkg::RST_CTRL;
			addr_q  <= uart_pkg::RST_CTRL;
			baud_q  <= uart_pkg::RST_BAUD;
		end else begin
			if (wsel(uart_pkg::OFS_CTRL0))
				ctrl0_q <= wdata_q[7:0];
			if (wsel(uart_pkg::OFS_CTRL1))
				ctrl1_q <= wdata_q[7:0];
			if (wsel(uart_pkg::OFS_ADDR))
				addr_q <= wdata_q[7:0];
			if (wsel(uart_pkg::OFS_BAUDH))
				baud_q[15:8] <= wdata_q[7:0];
			if (wsel(uart_pkg::OFS_BAUDL))
				baud_q[7:0] <= wdata_q[7:0];
		end
	end

	// Oversample tick divider
	logic tick;
	assign tick = baud_cnt_q == 16'h0000;
	always_ff @(posedge clk) begin
		if (sys_rst || tick)
			baud_cnt_q <= baud_q - 16'h0001;
		else
			baud_cnt_q <= baud_cnt_q - 16'h0001;
	end

	// Transmit holding register
	logic tx_load;
	assign tx_load = tx_st_q == uart_pkg::ST_IDLE && tx_en && hold_full_q
		&& (!flow_en || !cts_s2);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hold_full_q <= 1'b0;
			tx_hold_q   <= 8'h00;
			tx_irq_q    <= 1'b0;
		end else begin
			if (wsel(uart_pkg::OFS_DATA)) begin
				hold_full_q <= 1'b1;
				tx_hold_q   <= wdata_q[7:0];
			end else if (tx_load) begin
				hold_full_q <= 1'b0;
			end
			tx_irq_q <= ~hold_full_q;
		end
	end

	// Transmit shifter
	logic [7:0]    tx_sh_q;
	logic [PW-1:0] tx_ph_q;
	logic [2:0]    tx_bit_q;
	logic          tx_ninth_q, tx_has9_q, tx_stop2_q, tx_end;
	assign tx_end = tick && tx_ph_q == PH_LAST;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_st_q    <= uart_pkg::ST_IDLE;
			txd_q      <= 1'b1;
			tx_sh_q    <= 8'h00;
			tx_ph_q    <= '0;
			tx_bit_q   <= 3'h0;
			tx_ninth_q <= 1'b0;
			tx_has9_q  <= 1'b0;
			tx_stop2_q <= 1'b0;
		end else begin
			if (tick)
				tx_ph_q <= tx_ph_q + 1'b1;
			unique case (tx_st_q)
				uart_pkg::ST_IDLE: begin
					txd_q <= 1'b1;
					if (tx_load) begin
						tx_sh_q    <= tx_hold_q;
						tx_ninth_q <= mp_en ? marker : ((^tx_hold_q) ^ par_odd);
						tx_has9_q  <= mp_en | par_en;
						tx_stop2_q <= stop2;
						tx_ph_q    <= '0;
						txd_q      <= 1'b0;
						tx_st_q    <= uart_pkg::ST_START;
					end
				end
				uart_pkg::ST_START: if (tx_end) begin
					txd_q    <= tx_sh_q[0];
					tx_bit_q <= 3'h0;
					tx_st_q  <= uart_pkg::ST_DATA;
				end
				uart_pkg::ST_DATA: if (tx_end) begin
					if (tx_bit_q == 3'h7) begin
						txd_q   <= tx_has9_q ? tx_ninth_q : 1'b1;
						tx_st_q <= tx_has9_q ? uart_pkg::ST_NINTH : uart_pkg::ST_STOP;
					end else begin
						tx_bit_q <= tx_bit_q + 3'h1;
						tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
						txd_q    <= tx_sh_q[1];
					end
				end
				uart_pkg::ST_NINTH: if (tx_end) begin
					txd_q   <= 1'b1;
					tx_st_q <= uart_pkg::ST_STOP;
				end
				uart_pkg::ST_STOP: if (tx_end) begin
					if (tx_stop2_q)
						tx_stop2_q <= 1'b0;
					else
						tx_st_q <= uart_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Receive shifter
	uart_pkg::ser_state_type rx_st_q;
	logic [7:0]    rx_sh_q;
	logic [PW-1:0] rx_ph_q;
	logic [2:0]    rx_bit_q;
	logic          rx_ninth_q, rx_has9_q, rx_done_q, rx_stop_q, rx_mid, rx_end;
	assign rx_mid = tick && rx_ph_q == PH_MID;
	assign rx_end = tick && rx_ph_q == PH_LAST;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_st_q    <= uart_pkg::ST_IDLE;
			rx_sh_q    <= 8'h00;
			rx_ph_q    <= '0;
			rx_bit_q   <= 3'h0;
			rx_ninth_q <= 1'b0;
			rx_has9_q  <= 1'b0;
			rx_done_q  <= 1'b0;
			rx_stop_q  <= 1'b0;
		end else begin
			rx_done_q <= 1'b0;
			if (tick)
				rx_ph_q <= rx_ph_q + 1'b1;
			unique case (rx_st_q)
				uart_pkg::ST_IDLE: if (rx_en && !line) begin
					rx_ph_q   <= '0;
					rx_has9_q <= mp_en | par_en;
					rx_st_q   <= uart_pkg::ST_START;
				end
				uart_pkg::ST_START: begin
					if (rx_mid && line)
						rx_st_q <= uart_pkg::ST_IDLE;
					else if (rx_end) begin
						rx_bit_q <= 3'h0;
						rx_st_q  <= uart_pkg::ST_DATA;
					end
				end
				uart_pkg::ST_DATA: begin
					if (rx_mid)
						rx_sh_q <= {line, rx_sh_q[7:1]};
					if (rx_end) begin
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == 3'h7)
							rx_st_q <= rx_has9_q ? uart_pkg::ST_NINTH : uart_pkg::ST_STOP;
					end
				end
				uart_pkg::ST_NINTH: begin
					if (rx_mid)
						rx_ninth_q <= line;
					if (rx_end)
						rx_st_q <= uart_pkg::ST_STOP;
				end
				uart_pkg::ST_STOP: if (rx_mid) begin
					rx_stop_q <= line;
					rx_done_q <= 1'b1;
					rx_st_q   <= uart_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Character qualification
	logic is_addr, par_bad, brk_det, addr_hit, deliver, want_irq, ninth_v;
	assign ninth_v  = rx_has9_q & rx_ninth_q;
	assign is_addr  = mp_en & ninth_v;
	assign par_bad  = par_en & ~mp_en & (rx_ninth_q != ((^rx_sh_q) ^ par_odd));
	assign brk_det  = ~rx_stop_q & rx_sh_q == 8'h00 & ~ninth_v;
	assign addr_hit = rx_sh_q == addr_q;

	always_comb begin
		deliver  = 1'b1;
		want_irq = 1'b1;
		if (mp_en) begin
			case (scheme)
				uart_pkg::SCH_ALL_ADDR: want_irq = is_addr;
				uart_pkg::SCH_MATCH: begin
					deliver  = is_addr ? addr_hit : matched_q;
					want_irq = deliver;
				end
				uart_pkg::SCH_DATA: begin
					deliver  = ~is_addr & matched_q;
					want_irq = deliver;
				end
				default: want_irq = 1'b1;
			endcase
		end
	end

	// Receive data register and status
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_data_q <= 8'h00;
			avail_q   <= 1'b0;
			perr_q    <= 1'b0;
			ferr_q    <= 1'b0;
			ovr_q     <= 1'b0;
			brk_q     <= 1'b0;
			marker_q  <= 1'b0;
			newfrm_q  <= 1'b0;
			irq_ok_q  <= 1'b0;
			matched_q <= 1'b0;
			first_q   <= 1'b0;
			rx_irq_q  <= 1'b0;
		end else begin
			if (rd_pop) begin
				avail_q <= 1'b0;
				perr_q  <= 1'b0;
				ferr_q  <= 1'b0;
				ovr_q   <= 1'b0;
				brk_q   <= 1'b0;
			end
			if (rx_done_q && mp_en && scheme[1] && is_addr) begin
				matched_q <= addr_hit;
				first_q   <= addr_hit;
			end
			if (rx_done_q && (deliver || brk_det)) begin
				if (avail_q && !rd_pop)
					ovr_q <= 1'b1;
				else begin
					rx_data_q <= rx_sh_q;
					avail_q   <= 1'b1;
					perr_q    <= par_bad;
					ferr_q    <= ~rx_stop_q;
					brk_q     <= brk_det;
					marker_q  <= is_addr;
					newfrm_q  <= first_q & ~is_addr & scheme[1];
					irq_ok_q  <= want_irq;
					if (!is_addr)
						first_q <= 1'b0;
				end
			end
			rx_irq_q <= (avail_q & irq_ok_q & data_irq)
				| perr_q | ferr_q | ovr_q | brk_q;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_tx_write_full: assert property (wsel(uart_pkg::OFS_DATA) |=> hold_full_q)
		else $error("holding register not full after write");
	a_tx_enable_gate: assert property (tx_st_q == uart_pkg::ST_IDLE && !tx_en
		|=> tx_st_q == uart_pkg::ST_IDLE)
		else $error("transmit started while disabled");
	a_cts_hold_off: assert property (tx_st_q == uart_pkg::ST_IDLE && flow_en && cts_s2
		|=> tx_st_q == uart_pkg::ST_IDLE)
		else $error("transmit started without clear to send");
	a_tx_start_bit: assert property (tx_load |=> !txd_q
		&& (!hold_full_q || $past(wsel(uart_pkg::OFS_DATA))))
		else $error("load did not begin a start bit");
	a_tx_marker_take: assert property (tx_load && mp_en |=> tx_ninth_q == $past(marker))
		else $error("multidrop ninth bit not taken from marker");
	a_tx_irq_level: assert property (!hold_full_q |=> tx_irq)
		else $error("transmit request low while holding empty");
	a_rx_enable_gate: assert property (rx_st_q == uart_pkg::ST_IDLE && !rx_en
		|=> rx_st_q == uart_pkg::ST_IDLE)
		else $error("receiver started while disabled");
	a_rx_avail_set: assert property (rx_done_q && deliver && !avail_q |=> avail_q)
		else $error("delivered character not flagged");
	a_rx_pop_clear: assert property (rd_pop && !rx_done_q |=> !avail_q)
		else $error("available flag not cleared by read");
	a_rx_addr_drop: assert property (rx_done_q && mp_en && scheme == uart_pkg::SCH_DATA
		&& is_addr && !avail_q |=> !avail_q)
		else $error("address character delivered in data only scheme");

	c_tx_frame: cover property (tx_st_q == uart_pkg::ST_STOP ##1 tx_st_q == uart_pkg::ST_IDLE);
	c_rx_char: cover property (rx_done_q && deliver);
	c_rx_overrun: cover property ($rose(ovr_q));
	c_mp_match: cover property (rx_done_q && is_addr && addr_hit);
endmodule
`default_nettype wire

// ===== hw/uart_pkg.sv
package uart_pkg;
	localparam logic [4:0] OFS_DATA  = 5'h00;
	localparam logic [4:0] OFS_STAT0 = 5'h04;
	localparam logic [4:0] OFS_CTRL0 = 5'h08;
	localparam logic [4:0] OFS_CTRL1 = 5'h0C;
	localparam logic [4:0] OFS_STAT1 = 5'h10;
	localparam logic [4:0] OFS_ADDR  = 5'h14;
	localparam logic [4:0] OFS_BAUDH = 5'h18;
	localparam logic [4:0] OFS_BAUDL = 5'h1C;
	localparam int C0_TX_EN   = 7;
	localparam int C0_RX_EN   = 6;
	localparam int C0_FLOW    = 5;
	localparam int C0_PAR_EN  = 4;
	localparam int C0_PAR_ODD = 3;
	localparam int C0_STOP2   = 1;
	localparam int C1_SCH_HI  = 7;
	localparam int C1_SCH_LO  = 6;
	localparam int C1_MP_EN   = 5;
	localparam int C1_MARKER  = 1;
	localparam int C1_DATA_IRQ = 0;
	localparam logic [1:0] SCH_ALL_ADDR = 2'h1;
	localparam logic [1:0] SCH_MATCH    = 2'h2;
	localparam logic [1:0] SCH_DATA     = 2'h3;
	localparam logic [7:0] RST_CTRL  = 8'h00;
	localparam logic [15:0] RST_BAUD = 16'h0001;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} ser_state_type;
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} axil_req_type;
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_type;
endpackage

// ===== test/async_serial_port_with_multidrop_tb.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_with_multidrop_tb;
	localparam int          LIMIT    = 20000;
	localparam logic [31:0] MD_CHARS = 32'h22421143;
	localparam logic [3:0]  MD_MARK  = 4'h5;
	localparam logic [11:0] MD_IRQ   = 12'h8C5;
	logic                   clk;
	logic                   sys_rst;
	logic                   pin_alt_en;
	uart_pkg::axil_req_type req;
	uart_pkg::axil_rsp_type rsp;
	logic                   rxd;
	logic                   cts_n;
	logic                   txd;
	logic                   tx_irq;
	logic                   rx_irq;
	logic [31:0]            v;
	logic [1:0]             resp;
	int                     fails;
	int                     n_compared;
	int                     cycles;

	uart_multidrop #(
		.OVS(8)
	) dut (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.bus_req   (req),
		.bus_rsp   (rsp),
		.pin_alt_en(pin_alt_en),
		.rxd       (rxd),
		.cts_n     (cts_n),
		.txd       (txd),
		.tx_irq    (tx_irq),
		.rx_irq    (rx_irq)
	);

	remote_node #(
		.BIT(8)
	) peer (
		.clk  (clk),
		.txd  (txd),
		.rxd  (rxd),
		.cts_n(cts_n)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic end_sim;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		req.awvalid <= 1'b1;
		req.awaddr  <= {27'h0, a};
		req.wvalid  <= 1'b1;
		req.wdata   <= {24'h0, d};
		forever begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) break;
		end
		resp = rsp.bresp;
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		req.arvalid <= 1'b1;
		req.araddr  <= {27'h0, a};
		forever begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) break;
		end
		d    = rsp.rdata;
		resp = rsp.rresp;
	endtask

	task automatic rchk(input logic [4:0] a, input logic [7:0] e);
		rd(a, v);
		chk(v, {24'h0, e});
	endtask

	// Waits a bounded time for one frame from the line
	task automatic frame(input logic [9:0] e);
		repeat (400) if (peer.got.size() == 0) @(posedge clk);
		chk(32'(peer.got.size()), 32'h1);
		if (peer.got.size() != 0) chk({22'h0, peer.got.pop_front()}, {22'h0, e});
	endtask

	task automatic quiet;
		repeat (200) @(posedge clk);
		chk(32'(peer.got.size()), 32'h0);
	endtask

	task automatic rx(input logic [7:0] d, input logic b9, input logic stp, input logic irq);
		peer.send(d, b9, stp);
		repeat (4) @(posedge clk);
		chk({31'h0, rx_irq}, {31'h0, irq});
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails++;
			end_sim;
		end
	end

	initial begin
		cycles      = 0;
		fails       = 0;
		n_compared  = 0;
		req         = '0;
		req.wstrb   = 4'hF;
		req.bready  = 1'b1;
		req.rready  = 1'b1;
		sys_rst     = 1'b1;
		pin_alt_en  = 1'b0;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk({31'h0, tx_irq}, 32'h1);
		rchk(uart_pkg::OFS_CTRL0, 8'h00);
		rchk(uart_pkg::OFS_CTRL1, 8'h00);
		rchk(uart_pkg::OFS_ADDR, 8'h00);
		rchk(uart_pkg::OFS_BAUDL, 8'h01);
		rchk(uart_pkg::OFS_STAT0, 8'h07);
		rchk(5'h1E, 8'h00);
		chk({30'h0, resp}, {30'h0, uart_pkg::RESP_DECERR});
		wr(5'h1E, 8'hFF);
		chk({30'h0, resp}, {30'h0, uart_pkg::RESP_DECERR});
		// Low byte first keeps the divider reload short while the test value stands
		wr(uart_pkg::OFS_BAUDL, 8'h34);
		chk({30'h0, resp}, {30'h0, uart_pkg::RESP_OKAY});
		wr(uart_pkg::OFS_BAUDH, 8'h12);
		rchk(uart_pkg::OFS_BAUDH, 8'h12);
		rchk(uart_pkg::OFS_BAUDL, 8'h34);
		wr(uart_pkg::OFS_BAUDH, 8'h00);
		wr(uart_pkg::OFS_BAUDL, 8'h01);
		pin_alt_en <= 1'b1;
		// Transmit while disabled, then enabled
		wr(uart_pkg::OFS_DATA, 8'hA5);
		repeat (2) @(posedge clk);
		chk({31'h0, tx_irq}, 32'h0);
		rchk(uart_pkg::OFS_STAT0, 8'h03);
		quiet;
		wr(uart_pkg::OFS_CTRL0, 8'h80);
		frame(10'h2A5);
		chk({31'h0, tx_irq}, 32'h1);
		wr(uart_pkg::OFS_DATA, 8'h01);
		wr(uart_pkg::OFS_DATA, 8'h80);
		frame(10'h201);
		frame(10'h280);
		// Two stop bits keep the transmitter busy past the first stop
		wr(uart_pkg::OFS_CTRL0, 8'h82);
		wr(uart_pkg::OFS_DATA, 8'h3C);
		frame(10'h23C);
		repeat (6) @(posedge clk);
		rchk(uart_pkg::OFS_STAT0, 8'h05);
		repeat (12) @(posedge clk);
		rchk(uart_pkg::OFS_STAT0, 8'h07);
		// Parity even then odd
		peer.mode(1'b1, 1'b0);
		wr(uart_pkg::OFS_CTRL0, 8'h90);
		wr(uart_pkg::OFS_DATA, 8'h07);
		frame(10'h307);
		wr(uart_pkg::OFS_CTRL0, 8'h98);
		wr(uart_pkg::OFS_DATA, 8'h07);
		frame(10'h207);
		// Marker replaces parity in multidrop mode
		wr(uart_pkg::OFS_CTRL1, 8'h22);
		wr(uart_pkg::OFS_DATA, 8'h3D);
		frame(10'h33D);
		wr(uart_pkg::OFS_CTRL1, 8'h20);
		wr(uart_pkg::OFS_DATA, 8'h03);
		frame(10'h203);
		wr(uart_pkg::OFS_CTRL1, 8'h00);
		// Flow control
		peer.mode(1'b0, 1'b1);
		wr(uart_pkg::OFS_CTRL0, 8'hA0);
		wr(uart_pkg::OFS_DATA, 8'h55);
		quiet;
		peer.mode(1'b0, 1'b0);
		frame(10'h255);
		peer.mode(1'b0, 1'b1);
		wr(uart_pkg::OFS_CTRL0, 8'h80);
		wr(uart_pkg::OFS_DATA, 8'h66);
		frame(10'h266);
		peer.mode(1'b0, 1'b0);
		// Receive
		wr(uart_pkg::OFS_CTRL0, 8'h40);
		wr(uart_pkg::OFS_CTRL1, 8'h01);
		rx(8'h5A, 1'b0, 1'b1, 1'b1);
		rchk(uart_pkg::OFS_STAT0, 8'h87);
		rchk(uart_pkg::OFS_DATA, 8'h5A);
		rchk(uart_pkg::OFS_STAT0, 8'h07);
		chk({31'h0, rx_irq}, 32'h0);
		wr(uart_pkg::OFS_CTRL1, 8'h00);
		rx(8'h11, 1'b0, 1'b1, 1'b0);
		rchk(uart_pkg::OFS_DATA, 8'h11);
		// Second character while the first is unread: overrun, first kept
		rx(8'h21, 1'b0, 1'b1, 1'b0);
		rx(8'h22, 1'b0, 1'b1, 1'b1);
		rchk(uart_pkg::OFS_STAT0, 8'hA7);
		rchk(uart_pkg::OFS_DATA, 8'h21);
		rchk(uart_pkg::OFS_STAT0, 8'h07);
		peer.mode(1'b1, 1'b0);
		wr(uart_pkg::OFS_CTRL0, 8'h50);
		rx(8'h01, 1'b0, 1'b1, 1'b1);
		rd(uart_pkg::OFS_STAT0, v);
		chk(v & 32'h48, 32'h40);
		rd(uart_pkg::OFS_DATA, v);
		peer.mode(1'b0, 1'b0);
		wr(uart_pkg::OFS_CTRL0, 8'h40);
		rx(8'h00, 1'b0, 1'b0, 1'b1);
		rd(uart_pkg::OFS_STAT0, v);
		chk(v & 32'h08, 32'h08);
		rd(uart_pkg::OFS_DATA, v);
		wr(uart_pkg::OFS_CTRL0, 8'h00);
		rx(8'h33, 1'b0, 1'b1, 1'b0);
		rchk(uart_pkg::OFS_STAT0, 8'h07);
		wr(uart_pkg::OFS_CTRL0, 8'h40);
		pin_alt_en <= 1'b0;
		rx(8'h33, 1'b0, 1'b1, 1'b0);
		rchk(uart_pkg::OFS_STAT0, 8'h07);
		pin_alt_en <= 1'b1;
		// Multidrop schemes: foreign address, data, own address, data
		peer.mode(1'b1, 1'b0);
		wr(uart_pkg::OFS_ADDR, 8'h42);
		for (int s = 1; s < 4; s++) begin
			wr(uart_pkg::OFS_CTRL1, {s[1:0], 6'h21});
			for (int k = 0; k < 4; k++) begin
				rx(MD_CHARS[8*k+:8], MD_MARK[k], 1'b1, MD_IRQ[4*(s-1)+k]);
				if (MD_IRQ[4*(s-1)+k])
					rchk(uart_pkg::OFS_STAT1, {6'h00, (s > 1 && k == 3), MD_MARK[k]});
				rd(uart_pkg::OFS_DATA, v);
				if (MD_IRQ[4*(s-1)+k]) chk(v, {24'h0, MD_CHARS[8*k+:8]});
			end
		end
		end_sim;
	end
endmodule
`default_nettype wire

// ===== test/remote_node.sv
`timescale 1ns/1ps
`default_nettype none
module remote_node #(
	parameter int BIT = 8
) (
	// Clock
	input  wire logic clk,
	// Serial line
	input  wire logic txd,
	output logic      rxd,
	output logic      cts_n
);
	logic       nine;
	logic [9:0] got[$];

	initial begin
		rxd   = 1'b1;
		cts_n = 1'b0;
		nine  = 1'b0;
	end

	// Frame format and clear-to-send as this node presents them
	task automatic mode(input logic ninth_on, input logic busy);
		nine  = ninth_on;
		cts_n <= busy;
	endtask

	// Start, data lsb first, ninth when enabled, stop, then idle high
	task automatic send(input logic [7:0] d, input logic b9, input logic stp);
		logic [10:0] f;
		f = nine ? {stp, b9, d, 1'b0} : {1'b1, stp, d, 1'b0};
		for (int i = 0; i < 10 + nine; i++) begin
			@(posedge clk);
			rxd <= f[i];
			repeat (BIT - 1) @(posedge clk);
		end
		@(posedge clk);
		rxd <= 1'b1;
	endtask

	// Samples each outgoing bit in its middle, stores {stop, ninth, data}
	initial forever begin
		logic [9:0] v;
		@(negedge txd);
		v = '0;
		repeat (BIT / 2) @(posedge clk);
		if (txd === 1'b0) begin
			for (int i = 0; i <= 8 + nine; i++) begin
				repeat (BIT) @(posedge clk);
				v[(i == 8 + nine) ? 9 : i] = txd;
			end
			got.push_back(v);
		end
	end
endmodule
`default_nettype wire
